// >>> slsd_top.sv
// module: top of the serial-in latched sink driver
`timescale 1ns/100ps
`default_nettype none
module slsd_top (
  // system clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  // link clocks
  input  wire logic        shift_clock_i,
  input  wire logic        latch_clock_i,
  // link controls
  input  wire logic        chain_data_in_i,
  input  wire logic        global_clear_n_i,
  input  wire logic        output_enable_n_i,
  // sink outputs, enable high means sink conducting
  output logic [11:0]      sink_out_o,
  output logic [11:0]      sink_out_oe_o,
  // cascade
  output logic             cascade_data_out_o
);
  ////////////////////////////////////////////////////////////////////////////
  // shift-clock domain: serial stages and the falling-edge cascade flop
  ////////////////////////////////////////////////////////////////////////////
  // the link logic ignores reset_i; only the clear pin empties it
  slsd_link_if link ();

  slsd_shift_stage u_stage (
    .shift_clock_i    (shift_clock_i),
    .global_clear_n_i (global_clear_n_i),
    .chain_data_in_i  (chain_data_in_i),
    .link             (link)
  );

  // cascade leaves straight from the falling-edge flop; a copy re-timed into
  // clk_i would reach the next device several shift periods late
  assign cascade_data_out_o = link.cascade_bit;

  ////////////////////////////////////////////////////////////////////////////
  // latch-clock domain: storage register, blind to the shift clock
  ////////////////////////////////////////////////////////////////////////////
  slsd_pkg::slsd_word_t store_reg;
  slsd_pkg::slsd_word_t store_next;
  logic                 latch_tog_reg;
  logic                 latch_tog_next;

  always_comb begin
    store_next     = link.shift_word;
    latch_tog_next = !latch_tog_reg;
  end

  // the toggle announces a new word to clk_i; the word itself is read there
  // only after the toggle or the clear release has crossed, when it no longer moves
  always_ff @(posedge latch_clock_i or negedge global_clear_n_i) begin
    if (!global_clear_n_i) begin
      store_reg     <= slsd_pkg::STORE_RESET;
      latch_tog_reg <= 1'b0;
    end else begin
      store_reg     <= store_next;
      latch_tog_reg <= latch_tog_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clk_i domain: two-flop synchronisers, first stage read only by the second
  ////////////////////////////////////////////////////////////////////////////
  // clear, with a third stage to see its release
  logic clr_s1_reg;
  logic clr_s1_next;
  logic clr_s2_reg;
  logic clr_s2_next;
  logic clr_s3_reg;
  logic clr_s3_next;

  always_comb begin
    clr_s1_next = global_clear_n_i;
    clr_s2_next = clr_s1_reg;
    clr_s3_next = clr_s2_reg;
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      clr_s1_reg <= 1'b0;
      clr_s2_reg <= 1'b0;
      clr_s3_reg <= 1'b0;
    end else begin
      clr_s1_reg <= clr_s1_next;
      clr_s2_reg <= clr_s2_next;
      clr_s3_reg <= clr_s3_next;
    end
  end

  // enable, off until seen after reset_i
  logic oen_s1_reg;
  logic oen_s1_next;
  logic oen_s2_reg;
  logic oen_s2_next;

  always_comb begin
    oen_s1_next = output_enable_n_i;
    oen_s2_next = oen_s1_reg;
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      oen_s1_reg <= 1'b1;
      oen_s2_reg <= 1'b1;
    end else begin
      oen_s1_reg <= oen_s1_next;
      oen_s2_reg <= oen_s2_next;
    end
  end

  // latch toggle, third stage to see it flip
  // limitation: latch pulses closer than four clk_i periods can lose a word
  logic tog_s1_reg;
  logic tog_s1_next;
  logic tog_s2_reg;
  logic tog_s2_next;
  logic tog_s3_reg;
  logic tog_s3_next;

  always_comb begin
    tog_s1_next = latch_tog_reg;
    tog_s2_next = tog_s1_reg;
    tog_s3_next = tog_s2_reg;
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      tog_s1_reg <= 1'b0;
      tog_s2_reg <= 1'b0;
      tog_s3_reg <= 1'b0;
    end else begin
      tog_s1_reg <= tog_s1_next;
      tog_s2_reg <= tog_s2_next;
      tog_s3_reg <= tog_s3_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clk_i domain: copy of the storage word, taken while it stands still
  ////////////////////////////////////////////////////////////////////////////
  logic                 latch_seen;
  logic                 clear_left;
  logic                 word_fresh;
  slsd_pkg::slsd_word_t word_cap_reg;
  slsd_pkg::slsd_word_t word_cap_next;

  // clear_left also fires once after reset_i, on purpose: reset_i leaves
  // the storage register untouched, so its word is fetched again
  always_comb begin
    latch_seen    = tog_s2_reg ^ tog_s3_reg;
    clear_left    = clr_s2_reg && !clr_s3_reg;
    word_fresh    = latch_seen || clear_left;
    word_cap_next = word_cap_reg;
    if (!clr_s2_reg) begin
      word_cap_next = slsd_pkg::STORE_RESET;
    end else if (word_fresh) begin
      word_cap_next = store_reg;
    end
  end

  // a latch racing the clear release is caught again by its own toggle
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      word_cap_reg <= slsd_pkg::STORE_RESET;
    end else begin
      word_cap_reg <= word_cap_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clk_i domain: output gate, one slice per sink channel
  ////////////////////////////////////////////////////////////////////////////
  logic                 gate_open;
  slsd_pkg::slsd_word_t sink_reg;
  slsd_pkg::slsd_word_t sink_next;
  slsd_pkg::slsd_word_t level_reg;
  slsd_pkg::slsd_word_t level_next;

  always_comb begin
    gate_open  = clr_s2_reg && !oen_s2_reg;
    level_next = 12'h000;
  end

  for (genvar ch = 0; ch < slsd_pkg::CHANNELS; ch++) begin : g_sink
    // a stored one switches its sink on
    logic stored_one;
    assign stored_one    = word_cap_reg[ch];
    assign sink_next[ch] = gate_open && stored_one;
  end

  // one register stage so every output leaves a flop
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      sink_reg  <= slsd_pkg::STORE_RESET;
      level_reg <= 12'h000;
    end else begin
      sink_reg  <= sink_next;
      level_reg <= level_next;
    end
  end

  // open-drain: the pin level stays low and the enable switches the sink
  assign sink_out_o    = level_reg;
  assign sink_out_oe_o = sink_reg;
endmodule // slsd_top
`default_nettype wire

// >>> slsd_pkg.sv
// package: shared constants and types for the serial latched sink driver
package slsd_pkg;
  localparam int unsigned CHANNELS    = 12;
  localparam logic [11:0] SHIFT_RESET = 12'h000;
  localparam logic [11:0] STORE_RESET = 12'h000;
  localparam int unsigned LAST_STAGE  = 11;
  typedef logic [11:0] slsd_word_t;
endpackage

// >>> slsd_link_if.sv
// interface: shift-domain bundle between the link stage and the main module
`timescale 1ns/100ps
`default_nettype none
interface slsd_link_if;
  slsd_pkg::slsd_word_t shift_word;
  logic                 cascade_bit;
  modport stage (output shift_word, output cascade_bit);
  modport core  (input shift_word, input cascade_bit);
endinterface
`default_nettype wire

// >>> slsd_shift_stage.sv
// module: twelve-stage shift register on the shift clock with falling-edge cascade out
`timescale 1ns/100ps
`default_nettype none
module slsd_shift_stage (
  // clock and clear
  input  wire logic shift_clock_i,
  input  wire logic global_clear_n_i,
  // serial data
  input  wire logic chain_data_in_i,
  // bundle to core
  slsd_link_if.stage link
);
  slsd_pkg::slsd_word_t shift_reg;
  slsd_pkg::slsd_word_t shift_next;
  logic                 casc_reg;
  logic                 casc_next;

  always_comb begin
    shift_next = {shift_reg[slsd_pkg::LAST_STAGE-1:0], chain_data_in_i};
    casc_next  = shift_reg[slsd_pkg::LAST_STAGE];
  end

  // clear is asynchronous here because the link clock may be stopped while it is low
  always_ff @(posedge shift_clock_i or negedge global_clear_n_i) begin
    if (!global_clear_n_i) begin
      shift_reg <= slsd_pkg::SHIFT_RESET;
    end else begin
      shift_reg <= shift_next;
    end
  end

  always_ff @(negedge shift_clock_i or negedge global_clear_n_i) begin
    if (!global_clear_n_i) begin
      casc_reg <= 1'b0;
    end else begin
      casc_reg <= casc_next;
    end
  end

  assign link.shift_word  = shift_reg;
  assign link.cascade_bit = casc_reg;
endmodule // slsd_shift_stage
`default_nettype wire

// >>> slsd_monitor.sv
// checker: port properties of the sink driver top
`timescale 1ns/100ps
`default_nettype none
module slsd_monitor (
  // clocks, reset and controls
  input wire logic        clk_i,
  input wire logic        reset_i,
  input wire logic        shift_clock_i,
  input wire logic        latch_clock_i,
  input wire logic        global_clear_n_i,
  input wire logic        output_enable_n_i,
  // outputs
  input wire logic [11:0] sink_out_o,
  input wire logic [11:0] sink_out_oe_o,
  input wire logic        cascade_data_out_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  sequence s_still;
    global_clear_n_i && !output_enable_n_i && !latch_clock_i;
  endsequence
  sequence s_sck_idle;
    global_clear_n_i && $stable(shift_clock_i);
  endsequence
  chk_sink_low: assert property (sink_out_o == 12'h000) else $error("sink level");
  chk_enable_off: assert property (output_enable_n_i[*5] |-> !sink_out_oe_o) else $error("en");
  chk_enable_bound: assert property ($rose(output_enable_n_i) |-> ##[1:4] !sink_out_oe_o)
    else $error("en late");
  chk_clr_sinks: assert property (!global_clear_n_i[*5] |-> !sink_out_oe_o) else $error("clr");
  chk_clr_cascade: assert property (!global_clear_n_i[*5] |-> !cascade_data_out_o)
    else $error("clr cascade");
  chk_shift_apart: assert property (s_still[*6] |-> $stable(sink_out_oe_o)) else $error("shift");
  chk_cascade_quiet: assert property (s_sck_idle[*6] |-> $stable(cascade_data_out_o))
    else $error("cascade moved");
  chk_reset_idle: assert property ($fell(reset_i) |-> !sink_out_oe_o && !cascade_data_out_o)
    else $error("reset idle");
endmodule // slsd_monitor
bind slsd_top slsd_monitor i_slsd_monitor (
  .clk_i              (clk_i),
  .reset_i            (reset_i),
  .shift_clock_i      (shift_clock_i),
  .latch_clock_i      (latch_clock_i),
  .global_clear_n_i   (global_clear_n_i),
  .output_enable_n_i  (output_enable_n_i),
  .sink_out_o         (sink_out_o),
  .sink_out_oe_o      (sink_out_oe_o),
  .cascade_data_out_o (cascade_data_out_o)
);
`default_nettype wire

// >>> slsd_host_model.sv
// partner: host stream driving the shift and latch clocks
`timescale 1ns/100ps
`default_nettype none
module slsd_host_model (
  // serial stream to the driver
  output logic shift_clock_o,
  output logic data_o,
  output logic latch_clock_o
);
  initial {shift_clock_o, data_o, latch_clock_o} = 3'h0;
  // msb first so the first bit ends in stage 11
  task automatic shift_word(input slsd_pkg::slsd_word_t w);
    #3;
    for (int i = 11; i >= 0; i--) begin
      data_o = w[i];
      #16 shift_clock_o = 1'b1;
      #16 shift_clock_o = 1'b0;
    end
    data_o = ~data_o; // hold expired, no stale level
  endtask
  task automatic latch();
    #40 latch_clock_o = 1'b1;
    #60 latch_clock_o = 1'b0;
  endtask
endmodule // slsd_host_model
`default_nettype wire

// >>> slsd_top_tb.sv
// testbench: load, latch, gate and clear of the sink driver
`timescale 1ns/100ps
`default_nettype none
module slsd_top_tb;
  logic clk_i = 1'b0, reset_i = 1'b1, clr_n = 1'b0, en_n = 1'b1, sck, sd, lck, cas;
  logic [11:0] sink, oe;
  int miscompares = 0, n_tests = 0, cycles = 0;
  always #10 clk_i = ~clk_i;
  slsd_host_model i_slsd_host_model (.shift_clock_o(sck), .data_o(sd), .latch_clock_o(lck));
  slsd_top i_slsd_top (.clk_i(clk_i), .reset_i(reset_i), .shift_clock_i(sck),
    .latch_clock_i(lck), .chain_data_in_i(sd), .global_clear_n_i(clr_n),
    .output_enable_n_i(en_n), .sink_out_o(sink), .sink_out_oe_o(oe), .cascade_data_out_o(cas));
  task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic t_load;
    i_slsd_host_model.shift_word(12'hA5C);
    i_slsd_host_model.latch();
    wt(8);
    check("sinks", oe, 12'hA5C);
    check("cascade", {11'h000, cas}, 12'h001);
    check("level", sink, 12'h000);
    i_slsd_host_model.shift_word(12'h3F0);
    wt(8);
    check("held", oe, 12'hA5C);
    check("cascade", {11'h000, cas}, 12'h000);
    i_slsd_host_model.latch();
    wt(8);
    check("sinks", oe, 12'h3F0);
    $display("load done");
  endtask
  task automatic t_gate;
    en_n = 1'b1;
    wt(8);
    check("gated", oe, 12'h000);
    en_n = 1'b0;
    wt(8);
    check("open", oe, 12'h3F0);
    $display("gate done");
  endtask
  task automatic t_reset;
    reset_i = 1'b1;
    wt(4);
    reset_i = 1'b0;
    wt(8);
    check("kept", oe, 12'h3F0);
    $display("reset done");
  endtask
  task automatic t_clear;
    i_slsd_host_model.shift_word(12'hFFF);
    wt(1);
    clr_n = 1'b0;
    wt(8);
    check("cleared", oe, 12'h000);
    check("cascade", {11'h000, cas}, 12'h000);
    clr_n = 1'b1;
    i_slsd_host_model.latch();
    wt(8);
    check("empty", oe, 12'h000);
    $display("clear done");
  endtask
  task automatic results;
    $display("tests %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      results();
    end
  end
  initial begin
    wt(16);
    reset_i = 1'b0;
    clr_n = 1'b1;
    en_n = 1'b0;
    wt(2);
    t_load();
    t_gate();
    t_reset();
    t_clear();
    results();
  end
endmodule // slsd_top_tb
`default_nettype wire
